/* File: hdl/ca_pkg.sv */
// Functional notes
// - counter high byte at 0xFA, resets zero
// - high byte reads snapshot, loaded on low read
// - watchdog enabled blocks counter high byte writes
// - six low capture bytes, read/write, reset zero
// - reload select steers low byte to reload
// - six high capture bytes, read/write, reset zero
// - reload select steers high byte to reload
// - high capture byte write sets comparator enable
// - low capture bytes at FB,E9,EB,ED,FD,D2
// - high capture bytes at FC,EA,EC,EE,FE,D3
// - watchdog enabled blocks counter low byte writes
// - comparator enable gates counter match function
package ca_pkg;

  typedef logic [7:0] ca_byte_t;
  typedef logic [15:0] ca_word_t;

  localparam int CA_NUM_MODULES = 6;

  localparam ca_byte_t CA_SFR_PAGE = 8'h00;
  localparam ca_byte_t CA_ADDR_CNT_LOW = 8'hF9;
  localparam ca_byte_t CA_ADDR_CNT_HIGH = 8'hFA;

  // index 0 sits in the rightmost byte
  localparam logic [CA_NUM_MODULES-1:0][7:0] CA_ADDR_CAP_LOW =
    {8'hD2, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
  localparam logic [CA_NUM_MODULES-1:0][7:0] CA_ADDR_CAP_HIGH =
    {8'hD3, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};

  localparam ca_byte_t CA_RESET_BYTE = 8'h00;
  localparam ca_word_t CA_RESET_WORD = 16'h0000;
  localparam ca_byte_t CA_READ_IDLE = 8'h00;
  localparam ca_byte_t CA_BYTE_MAX = 8'hFF;
  localparam ca_byte_t CA_BYTE_ONE = 8'h01;

  function automatic logic [CA_NUM_MODULES-1:0] ca_decode(
    input ca_byte_t addr,
    input logic [CA_NUM_MODULES-1:0][7:0] map
  );
    logic [CA_NUM_MODULES-1:0] hit;
    hit = {CA_NUM_MODULES{1'h0}};
    for (int i = 0; i < CA_NUM_MODULES; i++) begin
      hit[i] = (addr == map[i]);
    end
    return hit;
  endfunction : ca_decode

endpackage : ca_pkg

/* File: hdl/ca_counter.sv */
`timescale 1ns/100ps
module ca_counter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // control
  input wire logic count_tick,
  input wire logic wd_lock,
  // register strobes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic rd_low,
  input wire ca_pkg::ca_byte_t wdata,
  // state
  output ca_pkg::ca_word_t count,
  output ca_pkg::ca_byte_t snap
);
  import ca_pkg::*;

  logic low_load;
  logic high_load;
  assign low_load = wr_low && !wd_lock;
  assign high_load = wr_high && !wd_lock;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count[7:0] <= CA_RESET_BYTE;
    end else if (low_load) begin
      count[7:0] <= wdata;
    end else if (count_tick) begin
      count[7:0] <= count[7:0] + CA_BYTE_ONE;
    end
  end

  // a written low byte swallows the carry of that cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count[15:8] <= CA_RESET_BYTE;
    end else if (high_load) begin
      count[15:8] <= wdata;
    end else if (count_tick && !low_load && count[7:0] == CA_BYTE_MAX) begin
      count[15:8] <= count[15:8] + CA_BYTE_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snap <= CA_RESET_BYTE;
    end else if (rd_low) begin
      snap <= count[15:8];
    end
  end

endmodule : ca_counter

/* File: hdl/ca_channel.sv */
`timescale 1ns/100ps
module ca_channel (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register strobes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic reload_sel,
  input wire ca_pkg::ca_byte_t wdata,
  // mode register path for the enable bit
  input wire logic enable_load,
  input wire logic enable_value,
  // state
  output ca_pkg::ca_word_t capture,
  output ca_pkg::ca_word_t reload,
  output logic cmp_enable
);
  import ca_pkg::*;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture <= CA_RESET_WORD;
    end else begin
      if (wr_low && !reload_sel) begin
        capture[7:0] <= wdata;
      end
      if (wr_high && !reload_sel) begin
        capture[15:8] <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload <= CA_RESET_WORD;
    end else begin
      if (wr_low && reload_sel) begin
        reload[7:0] <= wdata;
      end
      if (wr_high && reload_sel) begin
        reload[15:8] <= wdata;
      end
    end
  end

  // the high byte write wins over a clear from the mode register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_enable <= 1'h0;
    end else if (wr_high) begin
      cmp_enable <= 1'h1;
    end else if (enable_load) begin
      cmp_enable <= enable_value;
    end
  end

endmodule : ca_channel

/* File: hdl/ca_byte_access.sv */
`timescale 1ns/100ps
module ca_byte_access (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register bus from the core
  input wire ca_pkg::ca_byte_t sfr_addr,
  input wire ca_pkg::ca_byte_t sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire ca_pkg::ca_byte_t sfr_wdata,
  output ca_pkg::ca_byte_t sfr_rdata,
  // array control bits
  input wire logic watchdog_enable_bit,
  input wire logic reload_select_bit,
  input wire logic count_tick,
  input wire logic [ca_pkg::CA_NUM_MODULES-1:0] enable_load,
  input wire logic [ca_pkg::CA_NUM_MODULES-1:0] enable_value,
  // array state
  output ca_pkg::ca_word_t counter_value,
  output logic [ca_pkg::CA_NUM_MODULES-1:0][15:0] capture_value,
  output logic [ca_pkg::CA_NUM_MODULES-1:0][15:0] reload_value,
  output logic [ca_pkg::CA_NUM_MODULES-1:0] comparator_enable_bit,
  output logic [ca_pkg::CA_NUM_MODULES-1:0] compare_match
);
  import ca_pkg::*;

  logic page_ok;
  logic wr_ok;
  logic rd_ok;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic rd_cnt_low;
  logic [CA_NUM_MODULES-1:0] low_hit;
  logic [CA_NUM_MODULES-1:0] high_hit;
  ca_byte_t snap_high;
  ca_byte_t next_rdata;

  // only page 0 holds these registers
  assign page_ok = (sfr_page == CA_SFR_PAGE);
  assign wr_ok = sfr_wr && page_ok;
  assign rd_ok = sfr_rd && page_ok;
  assign wr_cnt_low = wr_ok && (sfr_addr == CA_ADDR_CNT_LOW);
  assign wr_cnt_high = wr_ok && (sfr_addr == CA_ADDR_CNT_HIGH);
  assign rd_cnt_low = rd_ok && (sfr_addr == CA_ADDR_CNT_LOW);
  assign low_hit = ca_decode(sfr_addr, CA_ADDR_CAP_LOW);
  assign high_hit = ca_decode(sfr_addr, CA_ADDR_CAP_HIGH);

  ca_counter u_counter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .count_tick(count_tick),
    .wd_lock(watchdog_enable_bit),
    .wr_low(wr_cnt_low),
    .wr_high(wr_cnt_high),
    .rd_low(rd_cnt_low),
    .wdata(sfr_wdata),
    .count(counter_value),
    .snap(snap_high)
  );

  for (genvar g = 0; g < CA_NUM_MODULES; g++) begin : g_chan
    ca_channel u_channel (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wr_low(wr_ok && low_hit[g]),
      .wr_high(wr_ok && high_hit[g]),
      .reload_sel(reload_select_bit),
      .wdata(sfr_wdata),
      .enable_load(enable_load[g]),
      .enable_value(enable_value[g]),
      .capture(capture_value[g]),
      .reload(reload_value[g]),
      .cmp_enable(comparator_enable_bit[g])
    );
  end

  // read mux; an unmapped address or page reads as zero
  always_comb begin
    next_rdata = CA_READ_IDLE;
    if (page_ok) begin
      if (sfr_addr == CA_ADDR_CNT_LOW) begin
        next_rdata = counter_value[7:0];
      end else if (sfr_addr == CA_ADDR_CNT_HIGH) begin
        next_rdata = snap_high;
      end else begin
        for (int i = 0; i < CA_NUM_MODULES; i++) begin
          if (low_hit[i]) begin
            next_rdata = reload_select_bit ? reload_value[i][7:0]
                                           : capture_value[i][7:0];
          end
          if (high_hit[i]) begin
            next_rdata = reload_select_bit ? reload_value[i][15:8]
                                           : capture_value[i][15:8];
          end
        end
      end
    end
  end

  // read data lands one edge after the strobe and holds until the next read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= CA_READ_IDLE;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // match is registered, so it trails the counter by one edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_match <= {CA_NUM_MODULES{1'h0}};
    end else begin
      for (int i = 0; i < CA_NUM_MODULES; i++) begin
        compare_match[i] <= comparator_enable_bit[i]
          && (counter_value == capture_value[i]);
      end
    end
  end

  logic carry_in;
  assign carry_in = count_tick && (counter_value[7:0] == CA_BYTE_MAX);

  a_high_snapshot: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (rd_ok && sfr_addr == CA_ADDR_CNT_HIGH) |=>
      sfr_rdata == $past(snap_high))
    else $error("high byte read did not return the snapshot");

  a_snap_load: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_cnt_low |=> snap_high == $past(counter_value[15:8]))
    else $error("snapshot not loaded on low byte read");

  a_snap_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !rd_cnt_low |=> $stable(snap_high))
    else $error("snapshot changed without a low byte read");

  a_high_load: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_cnt_high && !watchdog_enable_bit) |=>
      counter_value[15:8] == $past(sfr_wdata))
    else $error("unlocked high byte write did not load the counter");

  a_high_lock: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_cnt_high && watchdog_enable_bit) |=>
      counter_value[15:8] == ca_byte_t'($past(counter_value[15:8])
        + ($past(carry_in) ? CA_BYTE_ONE : CA_RESET_BYTE)))
    else $error("locked high byte write altered the counter");

  a_low_lock: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_cnt_low && watchdog_enable_bit) |=>
      counter_value[7:0] == ca_byte_t'($past(counter_value[7:0])
        + ($past(count_tick) ? CA_BYTE_ONE : CA_RESET_BYTE)))
    else $error("locked low byte write altered the counter");

  a_unmapped_read: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (sfr_rd && !page_ok) |=> sfr_rdata == CA_READ_IDLE)
    else $error("read from another page was not zero");

  a_rdata_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read strobe");

  a_low_read: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_cnt_low |=> sfr_rdata == $past(counter_value[7:0]))
    else $error("low byte read returned wrong data");

  a_unmapped_addr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (rd_ok && !(|low_hit) && !(|high_hit)
      && sfr_addr != CA_ADDR_CNT_LOW && sfr_addr != CA_ADDR_CNT_HIGH)
      |=> sfr_rdata == CA_READ_IDLE)
    else $error("read from an unmapped address was not zero");

  a_low_load: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_cnt_low && !watchdog_enable_bit) |=>
      counter_value[7:0] == $past(sfr_wdata))
    else $error("unlocked low byte write did not load the counter");

  a_low_no_carry: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_cnt_low && !watchdog_enable_bit) |=>
      counter_value[15:8] == $past(counter_value[15:8]))
    else $error("low byte write disturbed the high byte");

  a_high_keeps_low: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_cnt_high |=>
      counter_value[7:0] == ca_byte_t'($past(counter_value[7:0])
        + ($past(count_tick) ? CA_BYTE_ONE : CA_RESET_BYTE)))
    else $error("high byte write disturbed the low byte");

  a_count_step: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (count_tick && !wr_cnt_low && !wr_cnt_high) |=>
      counter_value == ca_word_t'($past(counter_value) + 16'h0001))
    else $error("counter did not advance by one");

  a_count_idle: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!count_tick && !wr_cnt_low && !wr_cnt_high) |=> $stable(counter_value))
    else $error("counter moved without a tick or write");

  a_page_write: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (sfr_wr && !page_ok) |=>
      $stable(capture_value) && $stable(reload_value))
    else $error("write on another page changed a capture byte");

  a_page_counter: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (sfr_wr && !page_ok && !count_tick) |=> $stable(counter_value))
    else $error("write on another page changed the counter");

  a_stray_write: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_ok && !(|low_hit) && !(|high_hit)) |=>
      $stable(capture_value) && $stable(reload_value))
    else $error("write outside the byte map changed a capture byte");

  for (genvar g = 0; g < CA_NUM_MODULES; g++) begin : g_check
    a_low_write: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && low_hit[g] && !reload_select_bit) |=>
        capture_value[g][7:0] == $past(sfr_wdata)
        && $stable(reload_value[g]))
      else $error("low capture byte write lost");

    a_low_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && low_hit[g] && reload_select_bit) |=>
        reload_value[g][7:0] == $past(sfr_wdata)
        && $stable(capture_value[g]))
      else $error("low reload byte write lost");

    a_high_write: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && high_hit[g] && !reload_select_bit) |=>
        capture_value[g][15:8] == $past(sfr_wdata))
      else $error("high capture byte write lost");

    a_high_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && high_hit[g] && reload_select_bit) |=>
        reload_value[g][15:8] == $past(sfr_wdata)
        && $stable(capture_value[g]))
      else $error("high reload byte write lost");

    a_enable_set: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && high_hit[g]) |=> comparator_enable_bit[g])
      else $error("high byte write did not set the comparator enable");

    a_match_cause: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      compare_match[g] |-> $past(comparator_enable_bit[g])
        && $past(counter_value) == $past(capture_value[g]))
      else $error("match raised without enable and equality");

    a_read_capture: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (rd_ok && high_hit[g] && !reload_select_bit) |=>
        sfr_rdata == $past(capture_value[g][15:8]))
      else $error("high capture byte read returned wrong data");

    a_read_low: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (rd_ok && low_hit[g] && !reload_select_bit) |=>
        sfr_rdata == $past(capture_value[g][7:0]))
      else $error("low capture byte read returned wrong data");

    a_read_low_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (rd_ok && low_hit[g] && reload_select_bit) |=>
        sfr_rdata == $past(reload_value[g][7:0]))
      else $error("low reload byte read returned wrong data");

    a_read_high_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (rd_ok && high_hit[g] && reload_select_bit) |=>
        sfr_rdata == $past(reload_value[g][15:8]))
      else $error("high reload byte read returned wrong data");

    a_low_keeps_high: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && low_hit[g] && !reload_select_bit) |=>
        capture_value[g][15:8] == $past(capture_value[g][15:8]))
      else $error("low capture byte write disturbed the high byte");

    a_high_cap_kept: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && high_hit[g] && !reload_select_bit) |=>
        capture_value[g][7:0] == $past(capture_value[g][7:0])
        && $stable(reload_value[g]))
      else $error("high capture byte write disturbed other bytes");

    a_reload_low_kept: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && low_hit[g] && reload_select_bit) |=>
        reload_value[g][15:8] == $past(reload_value[g][15:8]))
      else $error("low reload byte write disturbed the high byte");

    a_reload_high_kept: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_ok && high_hit[g] && reload_select_bit) |=>
        reload_value[g][7:0] == $past(reload_value[g][7:0]))
      else $error("high reload byte write disturbed the low byte");

    a_capture_hold: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !(wr_ok && (low_hit[g] || high_hit[g]) && !reload_select_bit) |=>
        $stable(capture_value[g]))
      else $error("capture value changed without a write");

    a_reload_hold: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !(wr_ok && (low_hit[g] || high_hit[g]) && reload_select_bit) |=>
        $stable(reload_value[g]))
      else $error("reload value changed without a write");

    a_enable_hold: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (!(wr_ok && high_hit[g]) && !enable_load[g]) |=>
        $stable(comparator_enable_bit[g]))
      else $error("comparator enable changed without a cause");

    a_enable_load: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (enable_load[g] && !(wr_ok && high_hit[g])) |=>
        comparator_enable_bit[g] == $past(enable_value[g]))
      else $error("comparator enable not loaded from the mode path");

    a_match_seen: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (comparator_enable_bit[g] && counter_value == capture_value[g]) |=>
        compare_match[g])
      else $error("enabled equality did not raise the match");

    a_match_off: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !comparator_enable_bit[g] |=> !compare_match[g])
      else $error("match raised while the comparator was disabled");
  end

endmodule : ca_byte_access

/* File: tb/ca_byte_access_test.sv */
`timescale 1ns/100ps
module ca_byte_access_test;
  import ca_pkg::*;
  logic ref_clk;
  logic arst_n;
  ca_byte_t sfr_addr;
  ca_byte_t sfr_page;
  logic sfr_wr;
  logic sfr_rd;
  ca_byte_t sfr_wdata;
  ca_byte_t sfr_rdata;
  logic watchdog_enable_bit;
  logic reload_select_bit;
  logic count_tick;
  logic [5:0] enable_load;
  logic [5:0] enable_value;
  ca_word_t counter_value;
  logic [5:0][15:0] capture_value;
  logic [5:0][15:0] reload_value;
  logic [5:0] comparator_enable_bit;
  logic [5:0] compare_match;
  int err_total = 0;
  int comparisons = 0;
  // address maps kept apart from the package on purpose
  ca_byte_t lo_map [6] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
  ca_byte_t hi_map [6] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};
  ca_byte_t b_lo;
  ca_byte_t b_hi;

  ca_byte_access DUT (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sfr_addr(sfr_addr),
    .sfr_page(sfr_page),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .watchdog_enable_bit(watchdog_enable_bit),
    .reload_select_bit(reload_select_bit),
    .count_tick(count_tick),
    .enable_load(enable_load),
    .enable_value(enable_value),
    .counter_value(counter_value),
    .capture_value(capture_value),
    .reload_value(reload_value),
    .comparator_enable_bit(comparator_enable_bit),
    .compare_match(compare_match)
  );

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input ca_byte_t a, input ca_byte_t d,
                    input ca_byte_t pg = 8'h00);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_page <= pg;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
    #1;
  endtask : wr

  task automatic rdchk(input string name, input ca_byte_t a,
                       input ca_byte_t exp, input ca_byte_t pg = 8'h00);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_page <= pg;
    sfr_rd <= 1'h1;
    @(posedge ref_clk);
    sfr_rd <= 1'h0;
    #1;
    chk(name, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask : rdchk

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // the whole sequence needs fewer than two hundred cycles
  initial begin
    #50000;
    err_total++;
    results();
  end

  initial begin
    arst_n = 1'h0;
    sfr_addr = 8'h00;
    sfr_page = 8'h00;
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    sfr_wdata = 8'h00;
    watchdog_enable_bit = 1'h0;
    reload_select_bit = 1'h0;
    count_tick = 1'h0;
    enable_load = 6'h00;
    enable_value = 6'h00;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'h1;
    rdchk("counter_high_byte", 8'hFA, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdchk("capture_low", lo_map[i], 8'h00);
      rdchk("capture_high", hi_map[i], 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      b_lo = ca_byte_t'(8'h10 + i);
      b_hi = ca_byte_t'(8'hA0 + i);
      wr(lo_map[i], b_lo);
      chk("enable_before", 16'h0000, 16'(comparator_enable_bit[i]));
      wr(hi_map[i], b_hi);
      chk("capture", {b_hi, b_lo}, capture_value[i]);
      chk("enable_after", 16'h0001, 16'(comparator_enable_bit[i]));
      rdchk("low_back", lo_map[i], b_lo);
      rdchk("high_back", hi_map[i], b_hi);
    end
    // reload path must leave the capture values alone
    @(posedge ref_clk);
    reload_select_bit <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      b_lo = ca_byte_t'(8'h50 + i);
      b_hi = ca_byte_t'(8'hC0 + i);
      wr(lo_map[i], b_lo);
      wr(hi_map[i], b_hi);
      chk("reload", {b_hi, b_lo}, reload_value[i]);
      chk("capture_kept", {8'hA0 + i[7:0], 8'h10 + i[7:0]},
          capture_value[i]);
      rdchk("reload_high", hi_map[i], b_hi);
      rdchk("reload_low", lo_map[i], b_lo);
    end
    @(posedge ref_clk);
    reload_select_bit <= 1'h0;
    wr(8'hF9, 8'h34);
    wr(8'hFA, 8'h12);
    chk("counter", 16'h1234, counter_value);
    rdchk("snapshot_stale", 8'hFA, 8'h00);
    rdchk("counter_low", 8'hF9, 8'h34);
    rdchk("snapshot", 8'hFA, 8'h12);
    wr(8'hFA, 8'h56);
    rdchk("snapshot_kept", 8'hFA, 8'h12);
    chk("counter", 16'h5634, counter_value);
    @(posedge ref_clk);
    watchdog_enable_bit <= 1'h1;
    wr(8'hF9, 8'hAA);
    wr(8'hFA, 8'hBB);
    chk("counter_locked", 16'h5634, counter_value);
    @(posedge ref_clk);
    watchdog_enable_bit <= 1'h0;
    wr(8'hF9, 8'hFE);
    @(posedge ref_clk);
    count_tick <= 1'h1;
    repeat (3) @(posedge ref_clk);
    count_tick <= 1'h0;
    #1;
    chk("counter_ticks", 16'h5701, counter_value);
    rdchk("counter_low", 8'hF9, 8'h01);
    rdchk("snapshot", 8'hFA, 8'h57);
    rdchk("page_read", hi_map[0], 8'h00, 8'h01);
    wr(lo_map[0], 8'h01);
    wr(hi_map[0], 8'h57);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("match_on", 16'h0001, {10'h000, compare_match});
    @(posedge ref_clk);
    enable_value <= 6'h00;
    enable_load <= 6'h01;
    @(posedge ref_clk);
    enable_load <= 6'h00;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("enable_cleared", 16'h0000, 16'(comparator_enable_bit[0]));
    chk("match_off", 16'h0000, {10'h000, compare_match});
    rdchk("unmapped", 8'h00, 8'h00);
    wr(hi_map[2], 8'h77, 8'h01);
    chk("other_page", 16'hA212, capture_value[2]);
    // reset in mid-run must clear everything, snapshot included
    @(posedge ref_clk);
    arst_n <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk("reset_counter", 16'h0000, counter_value);
    chk("reset_capture", 16'h0000, capture_value[2]);
    chk("reset_reload", 16'h0000, reload_value[2]);
    chk("reset_enable", 16'h0000, 16'(comparator_enable_bit));
    @(posedge ref_clk);
    arst_n <= 1'h1;
    rdchk("reset_snapshot", 8'hFA, 8'h00);
    results();
  end
endmodule : ca_byte_access_test
